// File: gmdc_debounce.sv
// One input debounce filter.
// Assumes the raw input is already synchronous to the clock.
`timescale 1ns/1ps
module gmdc_debounce #(
    parameter int CW = 27
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Input and setup
    input wire logic raw_i,
    input wire logic en_i,
    input wire logic [CW-1:0] limit_i,
    // Filtered level
    output logic filt_o
);
    logic [CW-1:0] cnt_reg;
    logic bypass;

    assign bypass = !en_i || (limit_i == '0);

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
            filt_o <= 1'b0;
        end else if (ce_i) begin
            if (bypass || raw_i == filt_o) begin
                cnt_reg <= '0;
                if (bypass) filt_o <= raw_i;
            end else if (cnt_reg >= limit_i - 1'b1) begin
                cnt_reg <= '0;
                filt_o <= raw_i;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    a_filter_hold: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        ce_i && !bypass && raw_i != filt_o && cnt_reg < limit_i - 1'b1
        |=> $stable(filt_o))
        else $error("filtered level moved before debounce time");
endmodule

// File: gmdc_host_model.sv
// Host processor model driving the block's register port.
// Assumes calls start just after a rising edge of the core clock.
`timescale 1ns/1ps
module gmdc_host_model (
    // Clock
    input wire logic core_clk_i,
    // Register port
    output logic [8:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic cfg_wr_en_i
);
    logic last_wr_en;

    initial begin
        reg_addr_o = 9'h1FF;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 8'hA5;
        last_wr_en = 1'b0;
    end

    // Idle bus shows flipped values so stale data never looks valid
    task automatic release_bus();
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~reg_addr_o;
        reg_wdata_o = ~reg_wdata_o;
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge core_clk_i);
        last_wr_en = cfg_wr_en_i;
        #1;
        release_bus();
        // Idle edge so a following call never re-drives in this step
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge core_clk_i);
        #1;
        release_bus();
        @(posedge core_clk_i);
        d = reg_rdata_i;
        #1;
    endtask

    // Write back exactly what was read, so later events survive
    task automatic clear_events(output logic [7:0] d);
        rd(9'h053, d);
        wr(9'h053, d);
    endtask
endmodule

// File: gmdc_pkg.sv
// Shared constants and types for the pin, mask and ramp control block.
// Assumes a single 100 MHz core clock and 9-bit register addresses.
package gmdc_pkg;
    // Register addresses
    localparam logic [8:0] ADDR_LEVEL = 9'h050;
    localparam logic [8:0] ADDR_STATUS = 9'h051;
    localparam logic [8:0] ADDR_EVENT = 9'h053;
    localparam logic [8:0] ADDR_MASK = 9'h055;
    localparam logic [8:0] ADDR_CTRL = 9'h056;
    localparam logic [8:0] ADDR_PIN01 = 9'h058;
    localparam logic [8:0] ADDR_PIN23 = 9'h059;
    localparam logic [8:0] ADDR_PIN4 = 9'h05A;
    localparam logic [8:0] LOCK_LO = 9'h0D0;
    localparam logic [8:0] LOCK_HI = 9'h14F;
    // Field positions
    localparam int CTRL_LOCK_BIT = 7;
    localparam int SLEW_B_LSB = 5;
    localparam int SLEW_A_LSB = 3;
    localparam int DEB_LSB = 0;
    localparam int MASK_OCB = 5;
    localparam int MASK_OCA = 4;
    localparam int MASK_CRIT = 3;
    localparam int MASK_WARN = 2;
    localparam int MASK_PGB = 1;
    localparam int MASK_PGA = 0;
    // Values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] PIN_RST = 8'h00;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int STEP_NS [4] = '{4000, 2000, 1000, 500};
    localparam int DEB_US [8] = '{0, 100, 1000, 10000, 50000,
                                  250000, 500000, 1000000};
    // Pin function codes
    localparam logic [1:0] FN_INPUT = 2'h0;
    localparam logic [1:0] FN_TRACK = 2'h1;
    localparam logic [1:0] FN_OD = 2'h2;
    localparam logic [1:0] FN_PP = 2'h3;

    typedef struct packed {
        logic debounce_on;
        logic polarity;
        logic [1:0] pin_function;
    } gmdc_pin_cfg_t;

    typedef struct packed {
        logic overcurrent_b;
        logic overcurrent_a;
        logic thermal_critical;
        logic thermal_warning;
        logic output_in_range_b;
        logic output_in_range_a;
    } gmdc_conv_t;
endpackage

// File: gmdc_ramp.sv
// Target ramp for one converter channel, one code step per interval.
// Assumes one code step equals 10 mV of output voltage.
`timescale 1ns/1ps
module gmdc_ramp #(
    parameter int W = 8
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Setup
    input wire logic [W-1:0] target_i,
    input wire logic [15:0] interval_i,
    // Ramp state
    output logic [W-1:0] level_o,
    output logic busy_o
);
    logic [15:0] cnt_reg;

    assign busy_o = level_o != target_i;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
            level_o <= '0;
        end else if (ce_i) begin
            if (!busy_o) begin
                cnt_reg <= '0;
            end else if (cnt_reg >= interval_i - 1'b1) begin
                cnt_reg <= '0;
                if (level_o < target_i) level_o <= level_o + 1'b1;
                else level_o <= level_o - 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    a_step_spacing: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        ce_i && busy_o && cnt_reg < interval_i - 1'b1
        |=> $stable(level_o))
        else $error("ramp stepped before its interval");
endmodule

// File: gmdc_top.sv
// Pin configuration, fault masking, write lock and ramp rate control.
// Assumes a register port from the serial interface decoder.
//
// What this block does
// - Mask bit 5 blocks channel B overcurrent event latch and interrupt.
// - Mask bit 4 blocks channel A overcurrent event latch and interrupt.
// - Mask bit 3 keeps critical thermal events off the interrupt.
// - Mask bit 2 keeps thermal warning events off the interrupt.
// - Mask bits 1 and 0 block in-range loss interrupts, B and A.
// - Lock bit 7 clear lets writes reach addresses 0xD0 to 0x14F.
// - Lock bit set drops all writes into the locked range.
// - Channel B ramps 10 mV per interval chosen by bits 6:5.
// - Channel A ramps 10 mV per interval chosen by bits 4:3.
// - Bits 2:0 choose the global debounce time, none up to 1000 ms.
// - Per-pin mode bit turns input debouncing off or on.
// - Per-pin polarity bit sets active level, 1 high, 0 low.
// - Output pins 2 and 3 drive active level when mode bit set.
// - Pins 2 and 3 select input, reserved, open-drain or push-pull.
// - Pin 0 selects input or tracking enable; pins 1 and 4 input.
// - Interrupt output low while any unmasked event bit is set.
// - Host clears events by write-back; new events are never lost.
`timescale 1ns/1ps
module gmdc_top
    import gmdc_pkg::*;
#(
    parameter int DEB_CYC_PER_US = CLK_MHZ,
    parameter int RAMP_W = 8
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [8:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic cfg_wr_en_o,
    // Converter monitors
    input wire gmdc_conv_t conv_i,
    // Ramp targets and state
    input wire logic [RAMP_W-1:0] ramp_target_a_i,
    input wire logic [RAMP_W-1:0] ramp_target_b_i,
    output logic [RAMP_W-1:0] ramp_level_a_o,
    output logic [RAMP_W-1:0] ramp_level_b_o,
    output logic ramp_busy_a_o,
    output logic ramp_busy_b_o,
    // General pins
    input wire logic [4:0] pin_i,
    output logic [1:0] pin23_o,
    output logic [1:0] pin23_oe_o,
    output logic [4:0] general_input_active_o,
    output logic tracking_enable_o,
    // Interrupt
    output logic interrupt_out_n_o
);
    localparam int DCW = 27;

    logic [7:0] ctrl_reg;
    logic [7:0] mask_reg;
    logic [7:0] pin01_reg;
    logic [7:0] pin23_reg;
    logic [3:0] pin4_reg;
    logic [5:0] event_reg;
    logic [5:0] event_next;
    logic [5:0] conv_prev_reg;
    logic [5:0] conv_now;
    logic [5:0] ev_raise;
    logic [5:0] ev_set;
    logic [5:0] ev_clear;
    logic [5:0] irq_mask;
    logic [4:0] pin_filt;
    logic [4:0] pin_active;
    gmdc_pin_cfg_t pin_cfg [5];
    logic [DCW-1:0] deb_limit;
    logic [15:0] step_a;
    logic [15:0] step_b;
    logic wr_ev;
    logic lock_range;
    logic [1:0] drive_lvl;

    function automatic logic [15:0] step_cycles(input logic [1:0] sel);
        step_cycles = 16'(STEP_NS[sel] * CLK_MHZ / 1000);
    endfunction

    function automatic logic [DCW-1:0] deb_cycles(input logic [2:0] sel);
        deb_cycles = DCW'(DEB_US[sel] * DEB_CYC_PER_US);
    endfunction

    // Locked range write gate
    assign lock_range = reg_addr_i >= LOCK_LO && reg_addr_i <= LOCK_HI;

    always_comb begin
        cfg_wr_en_o = 1'b0;
        if (ce_i && reg_wr_i && lock_range) begin
            cfg_wr_en_o = !ctrl_reg[CTRL_LOCK_BIT];
        end
    end

    // Control and pin configuration registers
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= CTRL_RST;
            mask_reg <= MASK_RST;
            pin01_reg <= PIN_RST;
            pin23_reg <= PIN_RST;
            pin4_reg <= PIN_RST[3:0];
        end else if (ce_i && reg_wr_i) begin
            case (reg_addr_i)
                ADDR_CTRL: ctrl_reg <= reg_wdata_i;
                ADDR_MASK: mask_reg <= {2'h0, reg_wdata_i[5:0]};
                ADDR_PIN01: pin01_reg <= reg_wdata_i;
                ADDR_PIN23: pin23_reg <= reg_wdata_i;
                ADDR_PIN4: pin4_reg <= reg_wdata_i[3:0];
                default: ;
            endcase
        end
    end

    // Per-pin configuration view
    assign pin_cfg[0] = gmdc_pin_cfg_t'(pin01_reg[3:0]);
    assign pin_cfg[1] = gmdc_pin_cfg_t'(pin01_reg[7:4]);
    assign pin_cfg[2] = gmdc_pin_cfg_t'(pin23_reg[3:0]);
    assign pin_cfg[3] = gmdc_pin_cfg_t'(pin23_reg[7:4]);
    assign pin_cfg[4] = gmdc_pin_cfg_t'(pin4_reg);

    // Event detection: faults on rising edge, in-range loss on falling
    assign conv_now = conv_i;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            conv_prev_reg <= 6'h00;
        end else if (ce_i) begin
            conv_prev_reg <= conv_now;
        end
    end

    assign ev_raise[5:2] = conv_now[5:2] & ~conv_prev_reg[5:2];
    assign ev_raise[1:0] = ~conv_now[1:0] & conv_prev_reg[1:0];

    always_comb begin
        ev_set = ev_raise;
        ev_set[MASK_OCB] = ev_raise[MASK_OCB] & ~mask_reg[MASK_OCB];
        ev_set[MASK_OCA] = ev_raise[MASK_OCA] & ~mask_reg[MASK_OCA];
    end

    assign wr_ev = reg_wr_i && reg_addr_i == ADDR_EVENT;
    assign ev_clear = wr_ev ? reg_wdata_i[5:0] : 6'h00;
    // Set wins so an event in the clearing cycle survives
    assign event_next = (event_reg & ~ev_clear) | ev_set;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            event_reg <= 6'h00;
        end else if (ce_i) begin
            event_reg <= event_next;
        end
    end

    // Interrupt from unmasked latched events
    assign irq_mask = mask_reg[5:0];

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            interrupt_out_n_o <= 1'b1;
        end else if (ce_i) begin
            interrupt_out_n_o <= ~|(event_reg & ~irq_mask);
        end
    end

    // Ramp rate selection
    assign step_b = step_cycles(ctrl_reg[SLEW_B_LSB +: 2]);
    assign step_a = step_cycles(ctrl_reg[SLEW_A_LSB +: 2]);

    gmdc_ramp #(
        .W(RAMP_W)
    ) u_ramp_a (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .target_i(ramp_target_a_i),
        .interval_i(step_a),
        .level_o(ramp_level_a_o),
        .busy_o(ramp_busy_a_o)
    );

    gmdc_ramp #(
        .W(RAMP_W)
    ) u_ramp_b (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .target_i(ramp_target_b_i),
        .interval_i(step_b),
        .level_o(ramp_level_b_o),
        .busy_o(ramp_busy_b_o)
    );

    // Debounce and active-level decode, one per pin
    assign deb_limit = deb_cycles(ctrl_reg[DEB_LSB +: 3]);

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_pin
            gmdc_debounce #(
                .CW(DCW)
            ) u_deb (
                .core_clk_i(core_clk_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .raw_i(pin_i[gi]),
                .en_i(pin_cfg[gi].debounce_on),
                .limit_i(deb_limit),
                .filt_o(pin_filt[gi])
            );
            // Polarity 0 means the low level is active
            assign pin_active[gi] =
                pin_filt[gi] ~^ pin_cfg[gi].polarity;
        end
    endgenerate

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            general_input_active_o <= 5'h00;
            tracking_enable_o <= 1'b0;
        end else if (ce_i) begin
            general_input_active_o <= pin_active;
            // Reserved codes fall back to plain input
            tracking_enable_o <= pin_cfg[0].pin_function == FN_TRACK
                && pin_active[0];
        end
    end

    // Wanted pin level: mode bit picks active or passive level
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            drive_lvl[i] = pin_cfg[i + 2].debounce_on
                ~^ pin_cfg[i + 2].polarity;
        end
    end

    // Output drivers for pins 2 and 3
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pin23_o <= 2'h0;
            pin23_oe_o <= 2'h0;
        end else if (ce_i) begin
            for (int i = 0; i < 2; i++) begin
                case (pin_cfg[i + 2].pin_function)
                    FN_PP: begin
                        pin23_o[i] <= drive_lvl[i];
                        pin23_oe_o[i] <= 1'b1;
                    end
                    FN_OD: begin
                        // Open drain only ever pulls low
                        pin23_o[i] <= 1'b0;
                        pin23_oe_o[i] <= !drive_lvl[i];
                    end
                    default: begin
                        pin23_o[i] <= 1'b0;
                        pin23_oe_o[i] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Register read back, one cycle after the read strobe
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i && reg_rd_i) begin
            case (reg_addr_i)
                ADDR_LEVEL: reg_rdata_o <= {3'h0, pin_filt};
                ADDR_STATUS: reg_rdata_o <= {2'h0, conv_now};
                ADDR_EVENT: reg_rdata_o <= {2'h0, event_reg};
                ADDR_MASK: reg_rdata_o <= mask_reg;
                ADDR_CTRL: reg_rdata_o <= ctrl_reg;
                ADDR_PIN01: reg_rdata_o <= pin01_reg;
                ADDR_PIN23: reg_rdata_o <= pin23_reg;
                ADDR_PIN4: reg_rdata_o <= {4'h0, pin4_reg};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_ocb_latch_mask: assert property (
        ce_i && mask_reg[MASK_OCB] && !event_reg[MASK_OCB]
        |=> !event_reg[MASK_OCB])
        else $error("masked channel B overcurrent latched");

    a_oca_latch_mask: assert property (
        ce_i && mask_reg[MASK_OCA] && !event_reg[MASK_OCA]
        |=> !event_reg[MASK_OCA])
        else $error("masked channel A overcurrent latched");

    a_crit_irq_mask: assert property (
        ce_i && (event_reg & ~irq_mask) == 6'h00
        ##1 ce_i && (event_reg & ~irq_mask) == 6'h00
        |=> interrupt_out_n_o)
        else $error("masked event drove the interrupt");

    a_unmasked_irq: assert property (
        ce_i && (event_reg & ~irq_mask) != 6'h00
        |=> !interrupt_out_n_o)
        else $error("unmasked event left interrupt high");

    a_lock_blocks: assert property (
        reg_wr_i && lock_range && ctrl_reg[CTRL_LOCK_BIT]
        |-> !cfg_wr_en_o)
        else $error("write passed while locked");

    a_unlock_passes: assert property (
        ce_i && reg_wr_i && lock_range && !ctrl_reg[CTRL_LOCK_BIT]
        |-> cfg_wr_en_o)
        else $error("write refused while unlocked");

    a_event_set_wins: assert property (
        ce_i && wr_ev && (ev_set & reg_wdata_i[5:0]) != 6'h00
        |=> (event_reg & $past(ev_set)) == $past(ev_set))
        else $error("event lost during clear");

    a_push_pull_oe: assert property (
        ce_i && pin_cfg[2].pin_function == FN_PP
        |=> pin23_oe_o[0])
        else $error("push-pull pin 2 not driven");

    a_track_enable: assert property (
        ce_i && pin_cfg[0].pin_function != FN_TRACK
        |=> !tracking_enable_o)
        else $error("tracking enable without selection");

    c_event_irq: cover property (
        ce_i && ev_set != 6'h00 ##2 !interrupt_out_n_o);
    c_event_clear: cover property (
        ce_i && wr_ev && event_reg != 6'h00);
    c_lock_refuse: cover property (
        reg_wr_i && lock_range && ctrl_reg[CTRL_LOCK_BIT]);
    c_od_drive: cover property (
        pin23_oe_o[1] && pin_cfg[3].pin_function == FN_OD);
endmodule

// File: gmdc_top_tb.sv
// Self-checking bench for the pin, mask, lock and ramp block.
// Assumes the host model owns the register port; debounce runs scaled.
`timescale 1ns/1ps
module gmdc_top_tb;
    import gmdc_pkg::*;
    logic core_clk_i, sys_rst_i, ce_i, reg_wr_i, reg_rd_i, cfg_wr_en_o;
    logic [8:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, tgt_a, tgt_b, lvl_a, lvl_b, v, d;
    gmdc_conv_t conv_i;
    logic busy_a, busy_b, trk, irq_n;
    logic [4:0] pin_i, gin, pol, msk;
    logic [1:0] pin23_o, pin23_oe_o;
    logic [7:0] e, g;
    logic [8:0] rst_addr [6];
    int num_errors, compares, cyc, n, ev, fn, lvl, oe;

    gmdc_top #(.DEB_CYC_PER_US(1)) dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .cfg_wr_en_o(cfg_wr_en_o), .conv_i(conv_i),
        .ramp_target_a_i(tgt_a), .ramp_target_b_i(tgt_b),
        .ramp_level_a_o(lvl_a), .ramp_level_b_o(lvl_b),
        .ramp_busy_a_o(busy_a), .ramp_busy_b_o(busy_b),
        .pin_i(pin_i), .pin23_o(pin23_o), .pin23_oe_o(pin23_oe_o),
        .general_input_active_o(gin), .tracking_enable_o(trk),
        .interrupt_out_n_o(irq_n));

    gmdc_host_model host (
        .core_clk_i(core_clk_i), .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
        .cfg_wr_en_i(cfg_wr_en_o));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Hang guard: well above the longest ramp and debounce runs
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_n(input int g, input int e);
        compares++;
        if (g != e) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask

    task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
        logic [7:0] r;
        host.rd(a, r);
        chk_v(r, e);
    endtask

    function automatic logic [7:0] cur(input int ch);
        return ch ? lvl_b : lvl_a;
    endfunction

    task automatic wait_chg(input int ch, output int k);
        logic [7:0] l0;
        l0 = cur(ch);
        k = 0;
        do begin
            step(1);
            k++;
        end while (cur(ch) === l0 && k < 1000);
    endtask

    task automatic ramp_gap(input int ch, input int code);
        int k;
        if (ch == 0) tgt_a = lvl_a + 8'h02;
        else tgt_b = lvl_b + 8'h02;
        wait_chg(ch, k);
        wait_chg(ch, k);
        chk_n(k, STEP_NS[code] * CLK_MHZ / 1000);
        step(2);
        chk_v(cur(ch), ch ? tgt_b : tgt_a);
        chk_v({6'h0, busy_b, busy_a}, 8'h00);
    endtask

    task automatic print_verdict();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        ce_i = 1'b1;
        sys_rst_i = 1'b1;
        conv_i = 6'h03;
        tgt_a = 8'h00;
        tgt_b = 8'h00;
        pin_i = 5'h00;
        num_errors = 0;
        compares = 0;
        cyc = 0;
        void'($urandom(1));
        repeat (5) @(posedge core_clk_i);
        #1 sys_rst_i = 1'b0;
        // Reset state
        rst_addr = '{ADDR_MASK, ADDR_CTRL, ADDR_PIN01, ADDR_PIN23, ADDR_PIN4,
                     ADDR_EVENT};
        foreach (rst_addr[i])
            rd_chk(rst_addr[i], 8'h00);
        chk_v({5'h0, irq_n, pin23_oe_o}, 8'h04);
        // Storage and reserved bits
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            host.wr(ADDR_MASK, v);
            rd_chk(ADDR_MASK, v & 8'h3F);
            host.wr(ADDR_PIN4, v);
            rd_chk(ADDR_PIN4, v & 8'h0F);
            host.wr(ADDR_PIN01, v);
            rd_chk(ADDR_PIN01, v);
        end
        host.wr(9'h057, 8'hFF);
        rd_chk(9'h057, 8'h00);
        // Write lock at both range ends
        for (int l = 0; l < 2; l++) begin
            host.wr(ADDR_CTRL, l ? 8'h80 : 8'h00);
            e = l ? 8'h00 : 8'h01;
            host.wr(LOCK_LO, 8'h5A);
            chk_v({7'h0, host.last_wr_en}, e);
            host.wr(LOCK_HI, 8'hA5);
            chk_v({7'h0, host.last_wr_en}, e);
        end
        rd_chk(ADDR_CTRL, 8'h80);
        host.wr(ADDR_CTRL, 8'h00);
        // Every event source, masked and unmasked
        for (int i = 0; i < 6; i++) begin
            for (int m = 0; m < 2; m++) begin
                host.wr(ADDR_MASK, m ? 8'(1 << i) : 8'h00);
                conv_i[i] = ~conv_i[i];
                step(1);
                conv_i[i] = ~conv_i[i];
                step(2);
                ev = (m == 1 && i >= 4) ? 0 : (1 << i);
                rd_chk(ADDR_EVENT, 8'(ev));
                e = (ev != 0 && m == 0) ? 8'h00 : 8'h01;
                chk_v({7'h0, irq_n}, e);
                host.clear_events(d);
                rd_chk(ADDR_EVENT, 8'h00);
                chk_v({7'h0, irq_n}, 8'h01);
            end
        end
        // Frozen enable, then a warning raised during its own clear
        ce_i = 1'b0;
        conv_i[2] = 1'b1;
        step(3);
        chk_v({7'h0, irq_n}, 8'h01);
        ce_i = 1'b1;
        step(3);
        chk_v({7'h0, irq_n}, 8'h00);
        conv_i[2] = 1'b0;
        fork
            host.clear_events(d);
            begin
                step(2);
                conv_i[2] = 1'b1;
            end
        join
        rd_chk(ADDR_EVENT, 8'h04);
        conv_i[2] = 1'b0;
        host.clear_events(d);
        rd_chk(ADDR_EVENT, 8'h00);
        // Pins 2 and 3 through all nibble codes
        for (int i = 0; i < 256; i++) begin
            host.wr(ADDR_PIN23, 8'(i));
            step(1);
            for (int p = 0; p < 2; p++) begin
                fn = (i >> (4 * p)) & 3;
                lvl = ((i >> (4 * p + 3)) & 1) == ((i >> (4 * p + 2)) & 1);
                oe = (fn == 3) ? 1 : (fn == 2) ? !lvl : 0;
                g = {6'h0, pin23_oe_o[p], pin23_o[p] & (fn >= 2)};
                e = 8'(oe * 2 + (fn == 3 && lvl));
                chk_v(g, e);
            end
        end
        host.wr(ADDR_PIN23, 8'h00);
        // Undebounced inputs with random levels and polarity
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            pin_i = 5'($urandom);
            host.wr(ADDR_PIN01, {1'b0, v[1], 3'b000, v[0], 1'b0, v[2]});
            host.wr(ADDR_PIN23, {1'b0, v[4], 3'b000, v[3], 2'b00});
            host.wr(ADDR_PIN4, {5'h0, v[5], 2'b00});
            step(3);
            pol = {v[5], v[4], v[3], v[1], v[0]};
            msk = v[2] ? 5'h1E : 5'h1F;
            e = {3'h0, ~(pin_i ^ pol) & msk};
            chk_v({3'h0, gin & msk}, e);
            chk_v({7'h0, trk}, {7'h0, v[2] & ~(pin_i[0] ^ v[0])});
            rd_chk(ADDR_LEVEL, {3'h0, pin_i});
        end
        // Debounce: glitch rejected, steady change after the set time
        host.wr(ADDR_PIN23, 8'h00);
        host.wr(ADDR_PIN4, 8'h04);
        host.wr(ADDR_PIN01, 8'hC4);
        for (int c = 1; c < 3; c++) begin
            host.wr(ADDR_CTRL, 8'(c));
            pin_i = 5'h00;
            step(DEB_US[c] + 20);
            pin_i = 5'h03;
            step(3);
            chk_v({6'h0, gin[1:0]}, 8'h01);
            step(DEB_US[c] / 2);
            pin_i = 5'h01;
            step(DEB_US[c] / 2 + 10);
            chk_v({6'h0, gin[1:0]}, 8'h01);
            pin_i = 5'h03;
            n = 0;
            while (gin[1] !== 1'b1 && n < 1100) begin
                step(1);
                n++;
            end
            chk_n(n >= DEB_US[c] && n <= DEB_US[c] + 3, 1);
        end
        // Ramp intervals, both channels, every code
        for (int k = 0; k < 4; k++) begin
            host.wr(ADDR_CTRL, 8'(((3 - k) << 5) | (k << 3)));
            ramp_gap(0, k);
            ramp_gap(1, 3 - k);
        end
        print_verdict();
    end
endmodule
